// ==== src/gpio_pkg.sv ====
// gpio_pkg: shared constants and types for the 32-pin general-purpose port bank.
// assumes one system clock and an active-low asynchronous reset everywhere.
package gpio_pkg;

  // bank geometry
  localparam int PIN_COUNT = 32;
  localparam int IDX_W     = 5;

  // pin modes; the last two are only reported by the mode query, never configured
  typedef enum logic [4:0] {
    mode_input,
    mode_input_pull_up,
    mode_input_pull_down,
    mode_output,
    mode_output_push_pull,
    mode_output_open_drain,
    mode_system_led,
    mode_wired_activity_led,
    mode_wireless_activity_led,
    mode_wired_link_led,
    mode_wireless_link_led,
    mode_wired_receive_led,
    mode_wireless_receive_led,
    mode_wired_send_led,
    mode_wireless_send_led,
    mode_peripheral,
    mode_soft_timer_output
  } mode_t;

  // initial level that goes with an output configuration
  typedef enum logic [1:0] {
    level_keep,
    level_low,
    level_high,
    level_toggle
  } level_t;

  // values after reset
  localparam mode_t              RESET_MODE  = mode_input;
  localparam logic               RESET_VALUE = 1'b0;
  localparam logic               RESET_LOCK  = 1'b0;
  localparam logic [PIN_COUNT-1:0] RESET_WORD = 32'h0000_0000;
  localparam logic [IDX_W-1:0]   RESET_INDEX = 5'h00;

endpackage

// ==== src/gpio_pin_cell.sv ====
// gpio_pin_cell: state and pad drive of one pin (mode, output value, lock).
// assumes the bank decodes commands into per-pin hits and supplies the led level.
`timescale 1ns/100ps
`default_nettype none

module gpio_pin_cell (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // decoded commands for this pin
  input  wire logic          cfg_hit,
  input  wire gpio_pkg::mode_t  cfg_mode,
  input  wire gpio_pkg::level_t cfg_level,
  input  wire logic          wr_hit,
  input  wire logic          wr_level,
  input  wire logic          lock_hit,
  input  wire logic          lock_level,
  input  wire logic          shared_busy,
  input  wire logic          led_level,
  // pin state
  output gpio_pkg::mode_t    mode_reg,
  output logic               value_reg,
  output logic               lock_reg,
  // pad drive
  output logic               drv_out_reg,
  output logic               drv_oe_reg,
  output logic               pull_up_reg,
  output logic               pull_down_reg
);
  import gpio_pkg::*;

  mode_t mode_next;
  logic  value_next;
  logic  lock_next;
  logic  drv_out_next;
  logic  drv_oe_next;
  logic  pull_up_next;
  logic  pull_down_next;

  // next mode, value, lock and the pad drive that follows from them
  always_comb begin
    mode_next      = mode_reg;
    value_next     = value_reg;
    lock_next      = lock_reg;
    if (cfg_hit) begin
      mode_next = cfg_mode;
    end
    // lock first so a blocked value write sees the old lock
    if (lock_hit) begin
      lock_next = lock_level;
    end
    if (shared_busy) begin
      lock_next = 1'b1;
    end
    if (!lock_reg) begin
      if (cfg_hit && cfg_level != level_keep) begin
        unique case (cfg_level)
          level_low:    value_next = 1'b0;
          level_high:   value_next = 1'b1;
          level_toggle: value_next = ~value_reg;
          level_keep:   value_next = value_reg;
        endcase
      end else if (wr_hit) begin
        value_next = wr_level;
      end
    end
    drv_out_next   = 1'b0;
    drv_oe_next    = 1'b0;
    pull_up_next   = 1'b0;
    pull_down_next = 1'b0;
    unique case (mode_next)
      mode_input: begin
      end
      mode_input_pull_up: begin
        pull_up_next = 1'b1;
      end
      mode_input_pull_down: begin
        pull_down_next = 1'b1;
      end
      mode_output, mode_output_push_pull: begin
        drv_out_next = value_next;
        drv_oe_next  = 1'b1;
      end
      mode_output_open_drain: begin
        drv_out_next = 1'b0;
        drv_oe_next  = ~value_next;
      end
      default: begin
        drv_out_next = led_level;
        drv_oe_next  = 1'b1;
      end
    endcase
  end

  // register pin state and drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg      <= RESET_MODE;
      value_reg     <= RESET_VALUE;
      lock_reg      <= RESET_LOCK;
      drv_out_reg   <= 1'b0;
      drv_oe_reg    <= 1'b0;
      pull_up_reg   <= 1'b0;
      pull_down_reg <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      value_reg     <= value_next;
      lock_reg      <= lock_next;
      drv_out_reg   <= drv_out_next;
      drv_oe_reg    <= drv_oe_next;
      pull_up_reg   <= pull_up_next;
      pull_down_reg <= pull_down_next;
    end
  end

endmodule

`default_nettype wire

// ==== src/gpio_bank.sv ====
// gpio_bank: 32-pin port bank with range configuration, led functions, output
// locks, bulk and single-pin access and per-pin queries.
// assumes synchronous command strobes and pad inputs; pads resolve out/oe/pulls.
// led sources, owners and pads are levels; commands are one-cycle strobes.
//
// How it works
// - a pull-up input turns on the pad pull-up so it idles high
// - a pull-down input turns on the pad pull-down so it idles low
// - output configuration may set the value low, high or toggled
// - push-pull drives high for value one and low for value zero
// - open-drain drives low for zero, releases for one; board pulls up
// - configuration covers one pin or an inclusive first-to-last range
// - activity led low while link is up, high during traffic
// - link led low while the chosen interface is connected
// - receive led low only while the interface receives
// - send led low only while the interface transmits
// - system led pin follows the system status level
// - each led function lives on one pin at most; duplicates are refused
// - each pin or range has a lock settable any time, clearable only while no shared peripheral or timer holds the pin
// - a locked pin ignores value writes and keeps its level
// - a pin taken by a shared peripheral or timer locks itself
// - bulk read returns all pin levels as one 32-bit word
// - bulk write updates every unlocked pin value from one word
// - single write sets one unlocked pin low or high
// - mode query reports mode, peripheral ownership or timer output
// - input query returns sampled pin level as 0 or 1
// - output query returns stored output value, unchanged by blocked writes
`timescale 1ns/100ps
`default_nettype none

module gpio_bank (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,

  // configuration command
  input  wire logic                          cfg_valid,
  input  wire logic [gpio_pkg::IDX_W-1:0]    cfg_first,
  input  wire logic [gpio_pkg::IDX_W-1:0]    cfg_last,
  input  wire gpio_pkg::mode_t               cfg_mode,
  input  wire gpio_pkg::level_t              cfg_level,
  output logic                               cfg_reject_reg,

  // lock command
  input  wire logic                          lock_valid,
  input  wire logic [gpio_pkg::IDX_W-1:0]    lock_first,
  input  wire logic [gpio_pkg::IDX_W-1:0]    lock_last,
  input  wire logic                          lock_set,

  // value writes
  input  wire logic                          bulk_wr_valid,
  input  wire logic [gpio_pkg::PIN_COUNT-1:0] bulk_wr_data,
  input  wire logic                          pin_wr_valid,
  input  wire logic [gpio_pkg::IDX_W-1:0]    pin_wr_index,
  input  wire logic                          pin_wr_level,

  // reads and queries
  output logic [gpio_pkg::PIN_COUNT-1:0]     bulk_rd_data_reg,
  input  wire logic [gpio_pkg::IDX_W-1:0]    query_index,
  output gpio_pkg::mode_t                    query_mode_reg,
  output logic                               query_input_reg,
  output logic                               query_output_reg,
  output logic [gpio_pkg::PIN_COUNT-1:0]     lock_word_reg,

  // shared peripheral and timer ownership
  input  wire logic [gpio_pkg::PIN_COUNT-1:0] peripheral_take,
  input  wire logic [gpio_pkg::PIN_COUNT-1:0] soft_timer_take,

  // led sources
  input  wire logic                          system_status,
  input  wire logic                          wired_link,
  input  wire logic                          wired_receiving,
  input  wire logic                          wired_sending,
  input  wire logic                          wireless_link,
  input  wire logic                          wireless_receiving,
  input  wire logic                          wireless_sending,

  // pads
  input  wire logic [gpio_pkg::PIN_COUNT-1:0] pin_in,
  output logic [gpio_pkg::PIN_COUNT-1:0]     pin_out,
  output logic [gpio_pkg::PIN_COUNT-1:0]     pin_oe,
  output logic [gpio_pkg::PIN_COUNT-1:0]     pin_pull_up,
  output logic [gpio_pkg::PIN_COUNT-1:0]     pin_pull_down
);
  import gpio_pkg::*;

  // per-pin state from the cells
  mode_t                mode_q   [PIN_COUNT];
  logic [PIN_COUNT-1:0] value_q;
  logic [PIN_COUNT-1:0] lock_q;

  // decoded per-pin commands
  logic [PIN_COUNT-1:0] cfg_range;
  logic [PIN_COUNT-1:0] cfg_hit;

  logic [PIN_COUNT-1:0] lock_hit;
  logic [PIN_COUNT-1:0] wr_hit;
  logic [PIN_COUNT-1:0] wr_level;
  logic [PIN_COUNT-1:0] led_level;
  logic [PIN_COUNT-1:0] holder_outside;
  logic [PIN_COUNT-1:0] shared_busy;

  // command qualification
  logic cfg_is_led;
  logic cfg_is_report_only;

  logic cfg_bad_range;
  logic cfg_conflict;
  logic cfg_ok;

  // registered answers
  logic                 cfg_reject_next;

  logic [PIN_COUNT-1:0] bulk_rd_data_next;
  mode_t                query_mode_next;
  logic                 query_input_next;
  logic                 query_output_next;
  logic [PIN_COUNT-1:0] lock_word_next;

  // classify the requested configuration
  always_comb begin
    cfg_is_led = 1'b0;
    cfg_is_report_only = 1'b0;

    unique case (cfg_mode)
      mode_system_led,
      mode_wired_activity_led,
      mode_wireless_activity_led,
      mode_wired_link_led,
      mode_wireless_link_led,
      mode_wired_receive_led,
      mode_wireless_receive_led,
      mode_wired_send_led,
      mode_wireless_send_led: cfg_is_led = 1'b1;

      // only an owner may report these two
      mode_peripheral,
      mode_soft_timer_output: cfg_is_report_only = 1'b1;
      mode_input,
      mode_input_pull_up,
      mode_input_pull_down,
      mode_output,
      mode_output_push_pull,
      mode_output_open_drain: begin
      end
      // a code past the last mode is refused like the report-only ones
      default: cfg_is_report_only = 1'b1;
    endcase
  end

  // range decode and led ownership check
  always_comb begin
    cfg_range      = '0;
    lock_hit       = '0;
    holder_outside = '0;

    for (int i = 0; i < PIN_COUNT; i++) begin
      cfg_range[i] = (IDX_W'(i) >= cfg_first)
                     && (IDX_W'(i) <= cfg_last);
      lock_hit[i]  = lock_valid && (IDX_W'(i) >= lock_first)
                     && (IDX_W'(i) <= lock_last);

      // same mode already held outside the range
      holder_outside[i] = (mode_q[i] == cfg_mode) && !cfg_range[i];
    end

    // reversed ranges hit no pin
    cfg_bad_range = cfg_first > cfg_last;

    // an led function may only land on a single pin not already held elsewhere
    cfg_conflict  = cfg_is_led
                    && ((cfg_first != cfg_last) || (|holder_outside));

    // refused commands are dropped whole
    cfg_ok        = cfg_valid && !cfg_bad_range && !cfg_conflict
                    && !cfg_is_report_only;
    cfg_hit       = cfg_ok ? cfg_range : '0;
    cfg_reject_next = cfg_valid && !cfg_ok;
  end

  // value writes; a single-pin write overrides the bulk bit of its pin
  always_comb begin
    wr_hit   = '0;
    wr_level = '0;

    for (int i = 0; i < PIN_COUNT; i++) begin
      // bulk bit n is the value of pin n
      if (bulk_wr_valid) begin
        wr_hit[i]   = 1'b1;
        wr_level[i] = bulk_wr_data[i];
      end

      // the single write wins on its own pin
      if (pin_wr_valid && pin_wr_index == IDX_W'(i)) begin
        wr_hit[i]   = 1'b1;
        wr_level[i] = pin_wr_level;
      end
    end
  end

  // led level per pin from its function and the network and system states
  always_comb begin
    led_level = '1;

    for (int i = 0; i < PIN_COUNT; i++) begin
      // the pad level each led function asks for
      unique case (mode_q[i])
        mode_system_led:            led_level[i] = system_status;
        mode_wired_activity_led:    led_level[i] = !wired_link
                                                   || wired_receiving
                                                   || wired_sending;
        mode_wireless_activity_led: led_level[i] = !wireless_link
                                                   || wireless_receiving
                                                   || wireless_sending;

        mode_wired_link_led:        led_level[i] = !wired_link;
        mode_wireless_link_led:     led_level[i] = !wireless_link;

        mode_wired_receive_led:     led_level[i] = !wired_receiving;
        mode_wireless_receive_led:  led_level[i] = !wireless_receiving;

        mode_wired_send_led:        led_level[i] = !wired_sending;
        mode_wireless_send_led:     led_level[i] = !wireless_sending;
        default:                    led_level[i] = 1'b1;
      endcase
    end
  end

  // pins held by a shared peripheral or the timer
  assign shared_busy = peripheral_take | soft_timer_take;

  // one cell per pin
  for (genvar g = 0; g < PIN_COUNT; g++) begin : gen_pin
    gpio_pin_cell u_cell (
      .clk           (clk),
      .rst_n         (rst_n),

      // commands for this pin
      .cfg_hit       (cfg_hit[g]),
      .cfg_mode      (cfg_mode),
      .cfg_level     (cfg_level),
      .wr_hit        (wr_hit[g]),
      .wr_level      (wr_level[g]),
      .lock_hit      (lock_hit[g]),
      .lock_level    (lock_set),
      .shared_busy   (shared_busy[g]),
      .led_level     (led_level[g]),

      // state back to the bank
      .mode_reg      (mode_q[g]),
      .value_reg     (value_q[g]),
      .lock_reg      (lock_q[g]),

      // pad controls
      .drv_out_reg   (pin_out[g]),
      .drv_oe_reg    (pin_oe[g]),
      .pull_up_reg   (pin_pull_up[g]),
      .pull_down_reg (pin_pull_down[g])
    );
  end

  // read and query answers
  always_comb begin
    bulk_rd_data_next = pin_in;
    query_input_next  = pin_in[query_index];
    query_output_next = value_q[query_index];

    lock_word_next    = lock_q;

    // an owner's report beats the configured mode
    if (peripheral_take[query_index]) begin
      query_mode_next = mode_peripheral;
    end else if (soft_timer_take[query_index]) begin
      query_mode_next = mode_soft_timer_output;
    end else begin
      query_mode_next = mode_q[query_index];
    end
  end

  // register answers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // every answer idles at zero
      cfg_reject_reg   <= 1'b0;

      bulk_rd_data_reg <= RESET_WORD;
      query_mode_reg   <= RESET_MODE;
      query_input_reg  <= 1'b0;
      query_output_reg <= RESET_VALUE;
      lock_word_reg    <= RESET_WORD;
    end else begin
      cfg_reject_reg   <= cfg_reject_next;

      bulk_rd_data_reg <= bulk_rd_data_next;
      query_mode_reg   <= query_mode_next;
      query_input_reg  <= query_input_next;
      query_output_reg <= query_output_next;
      lock_word_reg    <= lock_word_next;
    end
  end

endmodule

`default_nettype wire

// ==== verif/gpio_bank_chk.sv ====
// gpio_bank_chk: concurrent checks on the port bank's answers and pad controls.
// assumes it is bound into gpio_bank and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module gpio_bank_chk (
  // clock and reset
  input wire logic                           clk,
  input wire logic                           rst_n,
  // configuration command and its answer
  input wire logic                           cfg_valid,
  input wire logic [gpio_pkg::IDX_W-1:0]     cfg_first,
  input wire logic [gpio_pkg::IDX_W-1:0]     cfg_last,
  input wire gpio_pkg::mode_t                cfg_mode,
  input wire logic                           cfg_reject_reg,
  // reads, queries and ownership
  input wire logic [gpio_pkg::PIN_COUNT-1:0] bulk_rd_data_reg,
  input wire logic [gpio_pkg::IDX_W-1:0]     query_index,
  input wire gpio_pkg::mode_t                query_mode_reg,
  input wire logic                           query_input_reg,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] lock_word_reg,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] peripheral_take,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] soft_timer_take,
  // pads
  input wire logic [gpio_pkg::PIN_COUNT-1:0] pin_in,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] pin_oe,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] pin_pull_up,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] pin_pull_down
);
  import gpio_pkg::*;
  // queried pin's level and owners, led class of the command
  logic in_q, periph_q, timer_q, led_q;
  assign in_q     = pin_in[query_index];
  assign periph_q = peripheral_take[query_index];
  assign timer_q  = soft_timer_take[query_index];
  assign led_q    = cfg_mode inside {[mode_system_led:mode_wireless_send_led]};
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_RANGE_REJECT: assert property (cfg_valid && cfg_first > cfg_last |=> cfg_reject_reg)
    else $error("reversed range not refused");
  AST_LED_SOLO: assert property (cfg_valid && led_q && cfg_first != cfg_last |=> cfg_reject_reg)
    else $error("led range not refused");
  AST_REPORT_ONLY: assert property (cfg_valid && cfg_mode >= mode_peripheral |=> cfg_reject_reg)
    else $error("report-only mode not refused");
  AST_REJECT_CAUSE: assert property (cfg_reject_reg |-> $past(cfg_valid))
    else $error("refusal without a command");
  AST_BULK_READ: assert property ($past(rst_n) |-> bulk_rd_data_reg == $past(pin_in))
    else $error("bulk read differs from pads");
  AST_QUERY_INPUT: assert property ($past(rst_n) |-> query_input_reg == $past(in_q))
    else $error("input query differs from pad");
  AST_FORCED_LOCK: assert property ($past(rst_n, 2) && $past(rst_n) |->
    (($past(peripheral_take, 2) | $past(soft_timer_take, 2)) & ~lock_word_reg) == '0)
    else $error("owned pin not locked");
  AST_QUERY_OWNER: assert property ($past(rst_n) && $past(periph_q) |-> query_mode_reg == mode_peripheral)
    else $error("owned pin not reported");
  AST_QUERY_TIMER: assert property ($past(rst_n) && $past(timer_q) && !$past(periph_q)
    |-> query_mode_reg == mode_soft_timer_output)
    else $error("timer pin not reported");
  AST_PULL_SAFE: assert property (((pin_pull_up | pin_pull_down) & (pin_oe | pin_pull_up & pin_pull_down)) == '0)
    else $error("pull on a driven pin or both pulls");
endmodule

bind gpio_bank gpio_bank_chk chk_u (.clk, .rst_n, .cfg_valid, .cfg_first, .cfg_last, .cfg_mode,
  .cfg_reject_reg, .bulk_rd_data_reg, .query_index, .query_mode_reg, .query_input_reg,
  .lock_word_reg, .peripheral_take, .soft_timer_take, .pin_in, .pin_oe, .pin_pull_up, .pin_pull_down);
`default_nettype wire

// ==== verif/gpio_pad_model.sv ====
// gpio_pad_model: board side of the pads: outside drivers, board pull-ups, loose pins.
// assumes pad controls straight from the bank; an undriven pin with no pad pull or board pull-up reads a flipping pattern.
`timescale 1ns/100ps
`default_nettype none

module gpio_pad_model (
  // clock
  input wire logic         clk,
  // pad controls from the bank
  input wire logic [31:0]  pin_out,
  input wire logic [31:0]  pin_oe,
  input wire logic [31:0]  pin_pull_up,
  input wire logic [31:0]  pin_pull_down,
  // board stimulus and result
  input wire logic [31:0]  ext_en,
  input wire logic [31:0]  ext_val,
  input wire logic [31:0]  board_pu,
  output logic [31:0]      pin_in
);
  logic [31:0] float_reg = 32'h5555_aaaa;
  // a loose pin must not look like a steady level
  always @(posedge clk) float_reg <= ~float_reg;
  // own drive first, then outside driver, pad pulls, board pull-up
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pull_up[i] | pin_pull_down[i]) pin_in[i] = pin_pull_up[i];
      else if (board_pu[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_reg[i];
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_gpio_bank.sv ====
// tb_gpio_bank: self-checking bench for the 32-pin port bank.
// assumes gpio_pad_model on the pads and gpio_bank_chk bound into the bank.
`timescale 1ns/100ps
`default_nettype none

module tb_gpio_bank;
  import gpio_pkg::*;
  // bank inputs, board stimulus and the mode query answer
  logic                 clk, rst_n, cfg_valid, lock_valid, lock_set;
  logic                 bulk_wr_valid, pin_wr_valid, pin_wr_level;
  logic [IDX_W-1:0]     cfg_first, cfg_last, lock_first, lock_last, pin_wr_index, query_index;
  mode_t                cfg_mode, query_mode_reg;
  level_t               cfg_level;
  logic [6:0]           src;
  logic [PIN_COUNT-1:0] bulk_wr_data, peripheral_take, soft_timer_take, ext_en, ext_val, board_pu;
  // bank outputs and the pad levels read back
  logic                 cfg_reject_reg, query_input_reg, query_output_reg;
  logic [PIN_COUNT-1:0] bulk_rd_data_reg, lock_word_reg, pin_in, pin_out, pin_oe;
  logic [PIN_COUNT-1:0] pin_pull_up, pin_pull_down;
  int                   failures = 0;
  int                   comparisons = 0;
  localparam logic [6:0] PATS [4] = '{7'h00, 7'h24, 7'h3f, 7'h52};

  gpio_bank dut_u (.clk, .rst_n, .cfg_valid, .cfg_first, .cfg_last, .cfg_mode, .cfg_level,
    .cfg_reject_reg, .lock_valid, .lock_first, .lock_last, .lock_set, .bulk_wr_valid,
    .bulk_wr_data, .pin_wr_valid, .pin_wr_index, .pin_wr_level, .bulk_rd_data_reg, .query_index,
    .query_mode_reg, .query_input_reg, .query_output_reg, .lock_word_reg, .peripheral_take,
    .soft_timer_take, .system_status(src[6]), .wired_link(src[5]), .wired_receiving(src[4]),
    .wired_sending(src[3]), .wireless_link(src[2]), .wireless_receiving(src[1]),
    .wireless_sending(src[0]), .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down);
  gpio_pad_model pads_u (.clk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .ext_en,
    .ext_val, .board_pu, .pin_in);

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare, count and report
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // command drivers: raise at one edge, drop at the taking edge
  task automatic settle;
    @(posedge clk);
    {cfg_valid, lock_valid, bulk_wr_valid, pin_wr_valid} <= 4'h0;
    #1;
  endtask
  task automatic cfg(logic [IDX_W-1:0] f, l, mode_t m, level_t v);
    @(posedge clk);
    {cfg_first, cfg_last, cfg_valid} <= {f, l, 1'b1};
    cfg_mode <= m;
    cfg_level <= v;
    settle();
  endtask
  task automatic lck(logic [IDX_W-1:0] f, l, logic s);
    @(posedge clk);
    {lock_first, lock_last, lock_set, lock_valid} <= {f, l, s, 1'b1};
    settle();
  endtask
  task automatic pwr(logic [IDX_W-1:0] i, logic v);
    @(posedge clk);
    {pin_wr_index, pin_wr_level, pin_wr_valid} <= {i, v, 1'b1};
    settle();
  endtask
  task automatic bwr(logic [31:0] d);
    @(posedge clk);
    {bulk_wr_data, bulk_wr_valid} <= {d, 1'b1};
    settle();
  endtask
  task automatic qry(logic [IDX_W-1:0] i);
    @(posedge clk);
    query_index <= i;
    @(posedge clk);
    #1;
  endtask
  function automatic logic led_exp(mode_t m, logic [6:0] s);
    case (m)
      mode_system_led: return s[6];
      mode_wired_activity_led: return ~s[5] | s[4] | s[3];
      mode_wireless_activity_led: return ~s[2] | s[1] | s[0];
      mode_wired_link_led: return ~s[5];
      mode_wireless_link_led: return ~s[2];
      mode_wired_receive_led: return ~s[4];
      mode_wireless_receive_led: return ~s[1];
      mode_wired_send_led: return ~s[3];
      default: return ~s[0];
    endcase
  endfunction

  // pulls idle levels, outside drive packed by pin number
  task automatic t_inputs;
    cfg(1, 1, mode_input_pull_up, level_keep);
    cfg(2, 2, mode_input_pull_down, level_keep);
    @(posedge clk);
    {ext_en, ext_val} <= {32'hff00_0000, 32'h8100_0000};
    repeat (2) @(posedge clk);
    #1;
    chk("bulk read", 32'h8100_0002, bulk_rd_data_reg & 32'hff00_0006);
    qry(1);
    chk("pull-up input", 32'h1, 32'(query_input_reg));
    chk("pull-up mode", 32'(mode_input_pull_up), 32'(query_mode_reg));
  endtask
  // range drive and the high, toggle and keep initial levels
  task automatic t_outputs;
    cfg(3, 6, mode_output_push_pull, level_high);
    chk("range drive", 32'h78, pin_oe & pin_out & 32'hfc);
    cfg(3, 6, mode_output, level_toggle);
    chk("toggle", 32'h78, pin_oe & ~pin_out & 32'h78);
    cfg(3, 6, mode_output_push_pull, level_keep);
    chk("keep", 32'h0, pin_out & 32'h78);
    cfg(5, 5, mode_output, level_high);
    chk("single pin", 32'h20, pin_out & 32'hf8);
  endtask
  // open drain releases high, pulls low
  task automatic t_open_drain;
    cfg(8, 8, mode_output_open_drain, level_high);
    @(posedge clk);
    #1;
    chk("drain released", 32'h1, 32'({pin_oe[8], pin_out[8], bulk_rd_data_reg[8]}));
    cfg(8, 8, mode_output_open_drain, level_low);
    @(posedge clk);
    #1;
    chk("drain low", 32'h4, 32'({pin_oe[8], pin_out[8], bulk_rd_data_reg[8]}));
  endtask
  // locked pins ignore bulk and single writes
  task automatic t_lock;
    lck(4, 5, 1'b1);
    bwr(32'h0000_0050);
    chk("bulk write", 32'h60, pin_out & 32'h78);
    pwr(4, 1'b1);
    qry(4);
    chk("blocked output", 32'h0, 32'(query_output_reg));
    chk("lock word", 32'h30, lock_word_reg);
    lck(4, 4, 1'b0);
    pwr(4, 1'b1);
    qry(4);
    chk("single write", 32'h1, 32'(query_output_reg));
    chk("lock word", 32'h20, lock_word_reg);
  endtask
  // every led function on one pin, then duplicates refused
  task automatic t_leds;
    mode_t m;
    for (int k = 0; k < 9; k++) begin
      m = mode_t'(int'(mode_system_led) + k);
      cfg(13, 13, m, level_keep);
      for (int p = 0; p < 4; p++) begin
        @(posedge clk);
        src <= PATS[p];
        @(posedge clk);
        #1;
        chk(m.name(), {31'h1, led_exp(m, PATS[p])}, 32'({pin_oe[13], pin_out[13]}));
      end
    end
    cfg(14, 14, mode_wireless_send_led, level_keep);
    chk("duplicate led", 32'h1, 32'(cfg_reject_reg));
    cfg(13, 14, mode_wired_link_led, level_keep);
    chk("led range", 32'h1, 32'(cfg_reject_reg));
    qry(14);
    chk("refused pin mode", 32'(mode_input), 32'(query_mode_reg));
  endtask
  // shared owners lock their pins and show in the mode query
  task automatic t_owner;
    @(posedge clk);
    {peripheral_take, soft_timer_take} <= {32'h0010_0000, 32'h0030_0000};
    lck(20, 21, 1'b0);
    qry(20);
    chk("owned mode", 32'(mode_peripheral), 32'(query_mode_reg));
    qry(21);
    chk("timer mode", 32'(mode_soft_timer_output), 32'(query_mode_reg));
    chk("forced lock", 32'h0030_0000, lock_word_reg & 32'h0030_0000);
  endtask
  // refused commands change nothing
  task automatic t_refuse;
    cfg(9, 9, mode_peripheral, level_keep);
    chk("report-only mode", 32'h1, 32'(cfg_reject_reg));
    cfg(7, 6, mode_output, level_high);
    chk("reversed range", 32'h1, 32'(cfg_reject_reg));
    chk("untouched pins", 32'h40, pin_oe & 32'h2c0);
  endtask

  // reset, then the scenarios in turn
  initial begin
    {cfg_valid, lock_valid, lock_set, bulk_wr_valid, pin_wr_valid, pin_wr_level, src} = '0;
    {cfg_first, cfg_last, lock_first, lock_last, pin_wr_index, query_index} = '0;
    {bulk_wr_data, peripheral_take, soft_timer_take, ext_en, ext_val} = '0;
    cfg_mode = mode_input;
    cfg_level = level_keep;
    board_pu = 32'h0000_0100;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    qry(0);
    chk("reset drive", 32'h0, pin_oe | lock_word_reg | 32'(query_mode_reg));
    t_inputs();
    t_outputs();
    t_open_drain();
    t_lock();
    t_leds();
    t_owner();
    t_refuse();
    end_sim();
  end
  // watchdog well past the roughly 150 cycles the scenarios need
  initial begin
    #100us;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
